// ### design/hfs_pkg.sv
// package: register map, field positions and mode codes of the switch fault shutdown block
package hfs_pkg;
	localparam int NUM_SWITCHES = 4;
	localparam int REG_W = 16;
	localparam int ADDR_W = 7;
	localparam logic [6:0] ADDR_SWITCH_FAULT_SHUTDOWN_CFG = 7'h07;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	// bits 4 and 2:0 are unused and must read zero
	localparam logic [15:0] CFG_WRITE_MASK = 16'hffe8;
	localparam int OV_RESTORE_LSB = 12;
	localparam int OT_INDIVIDUAL_BIT = 11;
	localparam int OV_SHUTDOWN_OFF_LSB = 7;
	localparam int LOWPOWER_OV_OFF_BIT = 6;
	localparam int UV_SHUTDOWN_OFF_BIT = 5;
	localparam int UV_RESTORE_BIT = 3;
	localparam logic [15:0] READ_UNMAPPED = 16'h0000;

	typedef enum logic [1:0] {
		HFS_MODE_NORMAL = 2'h0,
		HFS_MODE_STOP = 2'h1,
		HFS_MODE_SLEEP = 2'h2
	} hfs_mode_t;

	// gray along run -> hold -> latched off
	typedef enum logic [1:0] {
		HFS_CH_RUN = 2'h0,
		HFS_CH_HOLD = 2'h1,
		HFS_CH_OFF = 2'h3
	} hfs_ch_state_t;
endpackage

// ### design/hfs_switch_channel.sv
// one high-side switch: fault hold, saved state and restore policy
module hfs_switch_channel (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic req,
	input wire logic ov_kill,
	input wire logic ov_restore,
	input wire logic uv_kill,
	input wire logic uv_restore,
	input wire logic ot_kill,
	output logic en_q
);
	hfs_pkg::hfs_ch_state_t state_q;
	hfs_pkg::hfs_ch_state_t state_d;
	logic saved_q;
	logic ov_seen_q;
	logic uv_seen_q;
	logic fault;
	logic restore_ok;

	assign fault = ov_kill | uv_kill;
	assign restore_ok = (!ov_seen_q || ov_restore) && (!uv_seen_q || uv_restore);

	// ************************************************
	// state machine
	// ************************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			hfs_pkg::HFS_CH_RUN: begin
				if (ot_kill) begin
					state_d = hfs_pkg::HFS_CH_OFF;
				end else if (fault) begin
					state_d = hfs_pkg::HFS_CH_HOLD;
				end
			end
			hfs_pkg::HFS_CH_HOLD: begin
				if (ot_kill) begin
					state_d = hfs_pkg::HFS_CH_OFF;
				end else if (!fault) begin
					state_d = (restore_ok && saved_q) ? hfs_pkg::HFS_CH_RUN : hfs_pkg::HFS_CH_OFF;
				end
			end
			hfs_pkg::HFS_CH_OFF: begin
				// a latched-off switch waits for software to command it off first
				if (!req && !fault && !ot_kill) begin
					state_d = hfs_pkg::HFS_CH_RUN;
				end
			end
			default: state_d = hfs_pkg::HFS_CH_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= hfs_pkg::HFS_CH_RUN;
		end else if (clear) begin
			state_q <= hfs_pkg::HFS_CH_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			saved_q <= 1'b0;
		end else if (state_q == hfs_pkg::HFS_CH_RUN && fault) begin
			saved_q <= req;
		end
	end

	// causes of the hold accumulate so that both restore bits must agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ov_seen_q <= 1'b0;
			uv_seen_q <= 1'b0;
		end else if (state_q == hfs_pkg::HFS_CH_RUN || clear) begin
			ov_seen_q <= ov_kill;
			uv_seen_q <= uv_kill;
		end else if (state_q == hfs_pkg::HFS_CH_HOLD) begin
			ov_seen_q <= ov_seen_q | ov_kill;
			uv_seen_q <= uv_seen_q | uv_kill;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 1'b0;
		end else begin
			en_q <= !clear && (state_d == hfs_pkg::HFS_CH_RUN) && req;
		end
	end

	sequence s_ov_clears_no_restore;
		state_q == hfs_pkg::HFS_CH_HOLD && !fault && !ot_kill && !clear && ov_seen_q && !ov_restore;
	endsequence

	a_ov_stays_off: assert property (@(posedge clk) disable iff (!rst_n)
		s_ov_clears_no_restore |=> state_q == hfs_pkg::HFS_CH_OFF && !en_q)
		else $error("switch restored after overvoltage with restore off");

	a_fault_saves: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == hfs_pkg::HFS_CH_RUN && fault && !ot_kill && !clear)
		|=> state_q == hfs_pkg::HFS_CH_HOLD && saved_q == $past(req) && !en_q)
		else $error("fault did not hold switch with saved state");

	a_uv_restores: assert property (@(posedge clk) disable iff (!rst_n)
		(state_q == hfs_pkg::HFS_CH_HOLD && !fault && !ot_kill && !clear && saved_q
		&& !ov_seen_q && uv_seen_q && uv_restore && req) |=> en_q)
		else $error("switch not restored after undervoltage");
endmodule // hfs_switch_channel

// ### design/hfs_shutdown_ctrl.sv
// shutdown control register and fault policy for four high-side switches
// ************************************************
// What this block does
// - per-switch overvoltage restore or stay off
// - overtemperature shuts all or only affected
// - normal mode per-switch overvoltage shutdown disable
// - stop and sleep share overvoltage disable
// - undervoltage shuts all switches unless disabled
// - undervoltage restore or stay off
// - unused bits ignore writes, read zero
// - power-on or soft reset clears register
// - restart keeps configurable bits
// ************************************************
module hfs_shutdown_ctrl #(
	parameter int NUM_SW = hfs_pkg::NUM_SWITCHES
) (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic SOFT_RESET,
	input wire logic RESTART,
	input wire logic [hfs_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic [hfs_pkg::REG_W-1:0] REG_WDATA,
	input wire logic REG_RD,
	output logic [hfs_pkg::REG_W-1:0] REG_RDATA,
	input wire hfs_pkg::hfs_mode_t MODE,
	input wire logic SUPPLY_OV,
	input wire logic SUPPLY_UV,
	input wire logic [NUM_SW-1:0] OT_FLAG,
	input wire logic [NUM_SW-1:0] SWITCH_REQ,
	output logic [NUM_SW-1:0] HS_EN
);
	logic [hfs_pkg::REG_W-1:0] cfg_q;
	logic [hfs_pkg::REG_W-1:0] rdata_q;
	logic hit;
	logic normal_mode;
	logic ot_any;

	assign hit = REG_ADDR == hfs_pkg::ADDR_SWITCH_FAULT_SHUTDOWN_CFG;
	assign normal_mode = MODE == hfs_pkg::HFS_MODE_NORMAL;
	assign ot_any = |OT_FLAG;

	// ************************************************
	// register
	// ************************************************
	// reset clears, mask writes
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			cfg_q <= hfs_pkg::CFG_RESET;
		end else if (SOFT_RESET) begin
			cfg_q <= hfs_pkg::CFG_RESET;
		end else if (REG_WR && hit) begin
			cfg_q <= REG_WDATA & hfs_pkg::CFG_WRITE_MASK;
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rdata_q <= hfs_pkg::READ_UNMAPPED;
		end else if (REG_RD) begin
			if (hit) begin
				rdata_q <= cfg_q & hfs_pkg::CFG_WRITE_MASK;
			end else begin
				rdata_q <= hfs_pkg::READ_UNMAPPED;
			end
		end
	end

	assign REG_RDATA = rdata_q;

	// ************************************************
	// per-switch policy
	// ************************************************
	genvar i;
	generate
		for (i = 0; i < NUM_SW; i++) begin : g_sw
			logic ov_kill;
			logic ot_kill;
			assign ov_kill = SUPPLY_OV && (normal_mode ?
				!cfg_q[hfs_pkg::OV_SHUTDOWN_OFF_LSB + i] : !cfg_q[hfs_pkg::LOWPOWER_OV_OFF_BIT]);
			assign ot_kill = cfg_q[hfs_pkg::OT_INDIVIDUAL_BIT] ? OT_FLAG[i] : ot_any;
			hfs_switch_channel u_ch (
				.clk(CORE_CLK),
				.rst_n(RESETN),
				.clear(SOFT_RESET),
				.req(SWITCH_REQ[i]),
				.ov_kill(ov_kill),
				.ov_restore(cfg_q[hfs_pkg::OV_RESTORE_LSB + i]),
				.uv_kill(SUPPLY_UV && !cfg_q[hfs_pkg::UV_SHUTDOWN_OFF_BIT]),
				.uv_restore(cfg_q[hfs_pkg::UV_RESTORE_BIT]),
				.ot_kill(ot_kill),
				.en_q(HS_EN[i])
			);

			a_ov_normal_off: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
				(normal_mode && SUPPLY_OV && !cfg_q[hfs_pkg::OV_SHUTDOWN_OFF_LSB + i])
				|=> !HS_EN[i])
				else $error("switch on during normal mode overvoltage");

			a_ov_normal_ignore: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
				(normal_mode && cfg_q[hfs_pkg::OV_SHUTDOWN_OFF_LSB + i] && !SUPPLY_UV
				&& !ot_any && !SOFT_RESET && SWITCH_REQ[i] && HS_EN[i]) |=> HS_EN[i])
				else $error("switch dropped despite overvoltage shutdown off");

			a_ot_individual: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
				OT_FLAG[i] |=> !HS_EN[i])
				else $error("overheated switch not shut down");

			a_no_req_off: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
				!SWITCH_REQ[i] |=> !HS_EN[i])
				else $error("switch on without request");

			a_lowpower_ignore: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
				(!normal_mode && cfg_q[hfs_pkg::LOWPOWER_OV_OFF_BIT] && !SUPPLY_UV
				&& !ot_any && !SOFT_RESET && SWITCH_REQ[i] && HS_EN[i]) |=> HS_EN[i])
				else $error("switch dropped despite low-power overvoltage off");

			a_ot_spares: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
				(cfg_q[hfs_pkg::OT_INDIVIDUAL_BIT] && !OT_FLAG[i] && !SUPPLY_OV
				&& !SUPPLY_UV && !SOFT_RESET && SWITCH_REQ[i] && HS_EN[i]) |=> HS_EN[i])
				else $error("cool switch dropped under individual overtemperature");
		end
	endgenerate

	// ************************************************
	// register and soft reset checks
	// ************************************************
	// a soft reset in either cycle voids the expected read-back value
	sequence s_cfg_write;
		REG_WR && hit && !SOFT_RESET;
	endsequence

	sequence s_cfg_read;
		REG_RD && hit && !SOFT_RESET;
	endsequence

	a_unmapped_read: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(REG_RD && !hit) |=> REG_RDATA == '0)
		else $error("unmapped read nonzero");

	a_rdata_hold: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		!REG_RD |=> $stable(REG_RDATA))
		else $error("read data changed without read");

	a_reserved_cfg: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(cfg_q & ~hfs_pkg::CFG_WRITE_MASK) == '0)
		else $error("reserved bits stored nonzero");

	a_write_mask: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		s_cfg_write |=> cfg_q == ($past(REG_WDATA) & hfs_pkg::CFG_WRITE_MASK))
		else $error("write did not land masked");

	a_soft_cfg: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		SOFT_RESET |=> cfg_q == hfs_pkg::CFG_RESET)
		else $error("soft reset left configuration");

	a_soft_outputs: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		SOFT_RESET |=> HS_EN == '0)
		else $error("switch on after soft reset");

	a_cfg_quiet: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(!SOFT_RESET && !(REG_WR && hit)) |=> $stable(cfg_q))
		else $error("configuration changed without write");

	// ************************************************
	// fault policy checks, then further register checks
	// ************************************************
	// these see only the pins and cfg_q: channel-internal steps are checked in the channel

	a_ot_all_off: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(ot_any && !cfg_q[hfs_pkg::OT_INDIVIDUAL_BIT]) |=> HS_EN == '0)
		else $error("switch on during global overtemperature");

	a_lowpower_ov: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(!normal_mode && SUPPLY_OV && !cfg_q[hfs_pkg::LOWPOWER_OV_OFF_BIT]) |=> HS_EN == '0)
		else $error("switch on during low-power overvoltage");

	a_uv_all_off: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(SUPPLY_UV && !cfg_q[hfs_pkg::UV_SHUTDOWN_OFF_BIT]) |=> HS_EN == '0)
		else $error("switch on during undervoltage");

	a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(REG_RDATA & ~hfs_pkg::CFG_WRITE_MASK) == '0)
		else $error("reserved bits read nonzero");

	a_soft_clear: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		SOFT_RESET ##1 (REG_RD && hit && !SOFT_RESET && !REG_WR) |=> REG_RDATA == '0)
		else $error("soft reset did not clear register");

	a_write_read: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		s_cfg_write ##1 s_cfg_read
		|=> REG_RDATA == ($past(REG_WDATA, 2) & hfs_pkg::CFG_WRITE_MASK))
		else $error("written value not read back");

	a_restart_keep: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
		(RESTART && !SOFT_RESET && !(REG_WR && hit)) |=> cfg_q == $past(cfg_q))
		else $error("restart altered configuration");
endmodule // hfs_shutdown_ctrl

// ### sim/hfs_host_model.sv
// host side model: strobed single-word register reads and writes
module hfs_host_model (
	input wire logic clk,
	output logic [hfs_pkg::ADDR_W-1:0] reg_addr,
	output logic reg_wr,
	output logic [hfs_pkg::REG_W-1:0] reg_wdata,
	output logic reg_rd,
	input wire logic [hfs_pkg::REG_W-1:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_addr = 7'h00;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd = 1'b0;
	end
	// ************************************************
	// access tasks
	// ************************************************
	// released lines flip so a stale value never passes for a fresh one
	// the address is left to the next access so a read may follow a write back to back
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	// called just after an edge; the strobe is sampled at the next one
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule // hfs_host_model

// ### sim/tb_top.sv
// self-checking bench for the switch fault shutdown block
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [6:0] CA = hfs_pkg::ADDR_SWITCH_FAULT_SHUTDOWN_CFG;
	logic core_clk;
	logic rst_n;
	logic soft_reset;
	logic restart;
	logic [6:0] reg_addr;
	logic reg_wr;
	logic [15:0] reg_wdata;
	logic reg_rd;
	logic [15:0] reg_rdata;
	hfs_pkg::hfs_mode_t mode;
	logic supply_ov;
	logic supply_uv;
	logic [3:0] ot_flag;
	logic [3:0] switch_req;
	logic [3:0] hs_en;
	logic [15:0] rdv;
	int errors = 0;
	int tests_run = 0;
	int cycles = 0;
	hfs_shutdown_ctrl hfs_shutdown_ctrl_i (.CORE_CLK(core_clk), .RESETN(rst_n),
		.SOFT_RESET(soft_reset), .RESTART(restart), .REG_ADDR(reg_addr), .REG_WR(reg_wr),
		.REG_WDATA(reg_wdata), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .MODE(mode),
		.SUPPLY_OV(supply_ov), .SUPPLY_UV(supply_uv), .OT_FLAG(ot_flag),
		.SWITCH_REQ(switch_req), .HS_EN(hs_en));
	hfs_host_model hfs_host_model_i (.clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// ************************************************
	// helpers and scenarios
	// ************************************************
	task automatic finish_test();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// each case ends by cycling the request low, which frees a latched-off switch
	task automatic fault(input logic [15:0] cfg, input hfs_pkg::hfs_mode_t m, input logic ov,
		input logic uv, input logic [3:0] ot, input logic [3:0] e_hold, input logic [3:0] e_aft);
		hfs_host_model_i.wr(CA, cfg);
		@(posedge core_clk);
		mode <= m;
		supply_ov <= ov;
		supply_uv <= uv;
		ot_flag <= ot;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("hs_en in fault", e_hold, hs_en)
		@(posedge core_clk);
		supply_ov <= 1'b0;
		supply_uv <= 1'b0;
		ot_flag <= 4'h0;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("hs_en after fault", e_aft, hs_en)
		@(posedge core_clk);
		switch_req <= 4'h0;
		mode <= hfs_pkg::HFS_MODE_NORMAL;
		@(posedge core_clk);
		switch_req <= 4'hf;
		repeat (2) @(posedge core_clk);
		#1;
		`CHK("hs_en rejoin", 4'hf, hs_en)
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		rst_n = 1'b0;
		soft_reset = 1'b0;
		restart = 1'b0;
		mode = hfs_pkg::HFS_MODE_NORMAL;
		supply_ov = 1'b0;
		supply_uv = 1'b0;
		ot_flag = 4'h0;
		switch_req = 4'hf;
		repeat (4) @(posedge core_clk);
		#1;
		`CHK("hs_en in reset", 4'h0, hs_en)
		@(posedge core_clk);
		rst_n <= 1'b1;
		hfs_host_model_i.rd(CA, rdv);
		`CHK("cfg after reset", 16'h0000, rdv)
		hfs_host_model_i.wr(7'h08, 16'h0000);
		hfs_host_model_i.wr(CA, 16'hffff);
		hfs_host_model_i.rd(CA, rdv);
		`CHK("cfg unused bits", 16'hffe8, rdv)
		hfs_host_model_i.rd(7'h08, rdv);
		`CHK("unmapped read", 16'h0000, rdv)
		@(posedge core_clk);
		restart <= 1'b1;
		@(posedge core_clk);
		restart <= 1'b0;
		hfs_host_model_i.rd(CA, rdv);
		`CHK("cfg after restart", 16'hffe8, rdv)
		@(posedge core_clk);
		soft_reset <= 1'b1;
		@(posedge core_clk);
		soft_reset <= 1'b0;
		hfs_host_model_i.rd(CA, rdv);
		`CHK("cfg after soft reset", 16'h0000, rdv)
		fault(16'h2280, hfs_pkg::HFS_MODE_NORMAL, 1'b1, 1'b0, 4'h0, 4'h5, 4'h7);
		fault(16'h0780, hfs_pkg::HFS_MODE_STOP, 1'b1, 1'b0, 4'h0, 4'h0, 4'h0);
		fault(16'h0040, hfs_pkg::HFS_MODE_SLEEP, 1'b1, 1'b0, 4'h0, 4'hf, 4'hf);
		fault(16'h0000, hfs_pkg::HFS_MODE_NORMAL, 1'b0, 1'b1, 4'h0, 4'h0, 4'h0);
		fault(16'h0008, hfs_pkg::HFS_MODE_NORMAL, 1'b0, 1'b1, 4'h0, 4'h0, 4'hf);
		fault(16'h0020, hfs_pkg::HFS_MODE_NORMAL, 1'b0, 1'b1, 4'h0, 4'hf, 4'hf);
		fault(16'h0000, hfs_pkg::HFS_MODE_NORMAL, 1'b0, 1'b0, 4'h1, 4'h0, 4'h0);
		fault(16'h0800, hfs_pkg::HFS_MODE_NORMAL, 1'b0, 1'b0, 4'h1, 4'he, 4'he);
		finish_test();
	end
endmodule // tb_top
